// >>> hw/flash_charger_defs.svh
// Timing counts and reset values for the flash charger control block.
// Assumes a 50 MHz clock; included by the package user files.
`ifndef FLASH_CHARGER_DEFS_SVH
`define FLASH_CHARGER_DEFS_SVH

// ============================================================
// Clock and timing
// ============================================================
`define FC_CLK_MHZ 50
`define FC_DEGLITCH_NS 1000
`define FC_DEGLITCH_CYCLES ((`FC_DEGLITCH_NS * `FC_CLK_MHZ + 999) / 1000)
`define FC_CNT_W 8

// ============================================================
// Reset values
// ============================================================
`define FC_RST_SWITCH 1'b0
`define FC_RST_LATCH 1'b0

`endif

// >>> hw/flash_charger_pkg.sv
// Types shared by the flash charger control block.
// Assumes nothing beyond a SystemVerilog compiler.
package flash_charger_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DELAY,
    ST_ON,
    ST_OFF,
    ST_DONE,
    ST_FAULT
  } charge_state_t;

  typedef struct packed {
    logic full_charge;
    logic zero_voltage;
    logic peak_current;
    logic overcurrent_trip;
    logic thermal_trip;
  } comparators_t;

  typedef struct packed {
    logic charging;
    logic full;
    logic overcurrent_latched;
    logic thermal_latched;
  } charge_status_t;

endpackage

// >>> hw/request_deglitch.sv
// Captures the charge request level and releases it after a settle delay.
// Assumes the request input is synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
`include "flash_charger_defs.svh"

module request_deglitch
  import flash_charger_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES = `FC_DEGLITCH_CYCLES
)(
  input wire logic i_clk, // System clock
  input wire logic i_srst, // Sync reset, active high
  input wire logic i_request, // Raw charge request level
  output logic o_captured, // Request held in flip-flop
  output logic o_enable // Delayed enable
);

  logic [`FC_CNT_W-1:0] count;
  logic [`FC_CNT_W-1:0] next_count;
  logic next_enable;

  assign next_count = !o_captured ? '0 :
                      (count == DELAY_CYCLES[`FC_CNT_W-1:0]) ? count : count + 8'h01;
  assign next_enable = o_captured && (count == DELAY_CYCLES[`FC_CNT_W-1:0]);

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_captured <= `FC_RST_LATCH;
      count <= '0;
      o_enable <= 1'b0;
    end
    else
    begin
      o_captured <= i_request;
      count <= i_request ? next_count : '0;
      o_enable <= i_request && next_enable;
    end
  end

endmodule
`default_nettype wire

// >>> hw/flash_charger_control.sv
// Flyback charger control for a photo flash capacitor, with flash gating.
// Assumes comparator and host inputs are synchronous to i_clk.
//
// Overview of operation
// - A session starts only on a high charge request, held in a flip-flop.
// - The internal enable rises after a settle delay so short noise cannot start charging.
// - A low charge request stops charging at once.
// - Charging ends when the full-charge comparator trips with the switch off.
// - A thermal trip, or an overcurrent trip with the switch on, stops charging.
// - After a forced stop a new high request restarts charging.
// - Once enabled, the first action is to turn the switch on.
// - With the switch on, the peak current comparator turns it off.
// - With the switch on, a zero-voltage comparator overcurrent reading stops charging and latches the overcurrent fault.
// - With the switch off, a zero crossing turns it back on.
// - The flash gate drives high only while permit and fire are both high; otherwise the pull-down drives.
// - A thermal trip latches charging off until the trip clears and the request goes low.
// - An overcurrent latch clears only after a low request and current below threshold.
`timescale 1ns/1ps
`default_nettype none
`include "flash_charger_defs.svh"

module flash_charger_control
  import flash_charger_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES = `FC_DEGLITCH_CYCLES
)(
  input wire logic i_clk, // System clock, 50 MHz
  input wire logic i_srst, // Sync reset, active high
  input wire logic i_charge_request_pin, // Host charge request level
  input wire comparators_t i_cmp, // Comparator and trip inputs
  input wire logic i_flash_permit, // Flash permit level
  input wire logic i_flash_fire, // Flash fire level
  output logic o_switch_on, // Power switch gate
  output logic o_gate_drive_high, // Flash gate pull-up drive
  output logic o_gate_drive_low, // Flash gate pull-down drive
  output logic o_charge_done, // Full charge reached
  output charge_status_t o_status // Session and fault state
);

  // ============================================================
  // Request capture and settle delay
  // ============================================================
  logic captured;
  logic internal_charge_enable;

  request_deglitch #(
    .DELAY_CYCLES(DELAY_CYCLES)
  ) u_deglitch (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_request(i_charge_request_pin),
    .o_captured(captured),
    .o_enable(internal_charge_enable)
  );

  // ============================================================
  // Fault latches
  // ============================================================
  logic thermal_latched;
  logic overcurrent_latched;
  logic req_low_seen;
  logic ocp_event;
  logic next_overcurrent;
  logic next_thermal;
  logic next_req_low_seen;
  charge_state_t state;
  charge_state_t next_state;

  // Overcurrent only counts while the switch conducts
  assign ocp_event = (state == ST_ON) && (i_cmp.overcurrent_trip || i_cmp.zero_voltage);
  // Set wins over clear in the same cycle
  assign next_req_low_seen = overcurrent_latched && (req_low_seen || !i_charge_request_pin);
  assign next_overcurrent = ocp_event ||
    (overcurrent_latched && !(next_req_low_seen && !i_cmp.peak_current));
  // Thermal recovery also needs a low request, so a still-high pin cannot restart
  assign next_thermal = i_cmp.thermal_trip ||
    (thermal_latched && i_charge_request_pin);

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      thermal_latched <= `FC_RST_LATCH;
      overcurrent_latched <= `FC_RST_LATCH;
      req_low_seen <= 1'b0;
    end
    else
    begin
      thermal_latched <= next_thermal;
      overcurrent_latched <= next_overcurrent;
      req_low_seen <= next_req_low_seen;
    end
  end

  // ============================================================
  // Switching state machine
  // ============================================================
  logic fault_any;
  logic stop_now;

  assign fault_any = thermal_latched || overcurrent_latched ||
                     i_cmp.thermal_trip || ocp_event;
  assign stop_now = !i_charge_request_pin || fault_any;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
      begin
        if (captured && !fault_any)
        begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY:
      begin
        if (stop_now)
        begin
          next_state = fault_any ? ST_FAULT : ST_IDLE;
        end
        else if (internal_charge_enable)
        begin
          next_state = ST_ON;
        end
      end
      ST_ON:
      begin
        if (stop_now)
        begin
          next_state = fault_any ? ST_FAULT : ST_IDLE;
        end
        else if (i_cmp.peak_current)
        begin
          next_state = ST_OFF;
        end
      end
      ST_OFF:
      begin
        if (stop_now)
        begin
          next_state = fault_any ? ST_FAULT : ST_IDLE;
        end
        else if (i_cmp.full_charge)
        begin
          next_state = ST_DONE;
        end
        else if (i_cmp.zero_voltage)
        begin
          next_state = ST_ON;
        end
      end
      ST_DONE:
      begin
        // Held off until the host drops the request
        if (!i_charge_request_pin)
        begin
          next_state = ST_IDLE;
        end
        else if (fault_any)
        begin
          next_state = ST_FAULT;
        end
      end
      ST_FAULT:
      begin
        if (!fault_any)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ============================================================
  // Outputs
  // ============================================================
  logic flash_gate;
  logic next_switch_on;

  assign next_switch_on = (next_state == ST_ON);
  // Both inputs must be high; tying them together gives single-wire control
  assign flash_gate = i_flash_permit && i_flash_fire;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_switch_on <= `FC_RST_SWITCH;
      o_gate_drive_high <= 1'b0;
      o_gate_drive_low <= 1'b1;
      o_charge_done <= 1'b0;
      o_status <= '0;
    end
    else
    begin
      o_switch_on <= next_switch_on;
      o_gate_drive_high <= flash_gate;
      o_gate_drive_low <= !flash_gate;
      o_charge_done <= (next_state == ST_DONE);
      o_status.charging <= (next_state == ST_ON) || (next_state == ST_OFF);
      o_status.full <= (next_state == ST_DONE);
      o_status.overcurrent_latched <= next_overcurrent;
      o_status.thermal_latched <= next_thermal;
    end
  end

endmodule
`default_nettype wire

// >>> verification/flash_charger_control_asserts.sv
// Port assertions for the flash charger control block.
// Bound to the top module from the bench top file.
`timescale 1ns/1ps
`default_nettype none
`include "flash_charger_defs.svh"
module flash_charger_control_asserts
  import flash_charger_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES = `FC_DEGLITCH_CYCLES
)(
  input wire logic i_clk, // System clock
  input wire logic i_srst, // Sync reset, active high
  input wire logic i_charge_request_pin, // Host charge request
  input wire comparators_t i_cmp, // Comparator and trip inputs
  input wire logic i_flash_permit, // Flash permit
  input wire logic i_flash_fire, // Flash fire
  input wire logic o_switch_on, // Power switch gate
  input wire logic o_gate_drive_high, // Flash gate pull-up
  input wire logic o_gate_drive_low, // Flash gate pull-down
  input wire logic o_charge_done, // Full charge reached
  input wire charge_status_t o_status // Session and fault state
);
  // ============================================================
  // Helpers
  int hi_cnt;
  always_ff @(posedge i_clk)
  begin
    hi_cnt <= (i_srst || !i_charge_request_pin) ? 0 : hi_cnt + 1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_run_off;
    o_status.charging && !o_switch_on && i_charge_request_pin;
  endsequence
  // ============================================================
  // Assertions
  gate_follow_a: assert property (!$past(i_srst) |->
    o_gate_drive_high == $past(i_flash_permit && i_flash_fire)) else $error("gate drive wrong");
  gate_pair_a: assert property (o_gate_drive_low == !o_gate_drive_high)
    else $error("gate pair wrong");
  stop_low_a: assert property (!i_charge_request_pin |=> !o_switch_on)
    else $error("no stop on low request");
  peak_off_a: assert property (o_switch_on && i_cmp.peak_current |=> !o_switch_on)
    else $error("no peak turn off");
  ovc_trip_a: assert property (o_switch_on && (i_cmp.zero_voltage ||
    i_cmp.overcurrent_trip) |=> !o_switch_on && o_status.overcurrent_latched)
    else $error("no overcurrent stop");
  therm_latch_a: assert property (i_cmp.thermal_trip |=>
    !o_switch_on && o_status.thermal_latched) else $error("no thermal stop");
  zero_on_a: assert property (s_run_off ##0 (i_cmp == 5'h08) |=> o_switch_on)
    else $error("no zero crossing turn on");
  full_stop_a: assert property (s_run_off ##0 (i_cmp.full_charge && !i_cmp.thermal_trip) |=>
    o_charge_done && !o_switch_on) else $error("no full stop");
  start_on_a: assert property ($rose(o_status.charging) |->
    o_switch_on && hi_cnt >= DELAY_CYCLES) else $error("bad session start");
  done_hold_a: assert property (o_charge_done |-> !o_switch_on)
    else $error("switch on after done");
endmodule
`default_nettype wire

// >>> verification/flash_host_model.sv
// Host model: drives charge request and flash controls.
// Tasks are called from the bench top; changes land 1 ns after an edge.
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  input wire logic i_clk, // System clock
  output var logic o_req, // Charge request level
  output var logic o_permit, // Flash permit
  output var logic o_fire // Flash fire
);
  initial
  begin
    o_req = 1'b0;
    o_permit = 1'b0;
    o_fire = 1'b0;
  end
  task automatic set_req(input logic v);
    @(posedge i_clk);
    #1 o_req = v;
  endtask
  task automatic set_flash(input logic permit, input logic fire);
    @(posedge i_clk);
    #1 o_permit = permit;
    o_fire = fire;
  endtask
endmodule
`default_nettype wire

// >>> verification/flash_charger_control_tb_top.sv
// Bench top for the flash charger control block.
// Host model drives request and flash; comparators are driven here.
`timescale 1ns/1ps
`default_nettype none
module flash_charger_control_tb_top;
  import flash_charger_pkg::*;
  localparam int unsigned DLY = 4;
  logic clk;
  logic srst;
  logic req;
  logic permit;
  logic fire;
  comparators_t cmp;
  logic sw;
  logic gh;
  logic gl;
  logic done;
  charge_status_t st;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  flash_host_model host (.i_clk(clk), .o_req(req), .o_permit(permit), .o_fire(fire));
  flash_charger_control #(.DELAY_CYCLES(DLY)) dut (.i_clk(clk), .i_srst(srst),
    .i_charge_request_pin(req), .i_cmp(cmp), .i_flash_permit(permit), .i_flash_fire(fire),
    .o_switch_on(sw), .o_gate_drive_high(gh), .o_gate_drive_low(gl), .o_charge_done(done),
    .o_status(st));
  // ============================================================
  // Shared tasks
  task automatic chk(input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: got %b want %b", $time, seen, exp);
    end
  endtask
  task automatic setc(input comparators_t v);
    @(posedge clk);
    #1 cmp = v;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic start();
    int n;
    n = 0;
    host.set_req(1'b1);
    while (n < 20 && !sw)
    begin
      tick(1);
      n++;
    end
    chk(sw, 1'b1);
    chk(n >= DLY + 1, 1'b1);
  endtask
  // ============================================================
  // Scenarios
  task automatic t_flash();
    for (int i = 0; i < 6; i++)
    begin
      logic p;
      p = (i < 4) ? i[1] : i[0];
      host.set_flash(p, i[0]);
      tick(2);
      chk(gh, p & i[0]);
      chk(gl, ~(p & i[0]));
    end
  endtask
  task automatic t_glitch();
    host.set_req(1'b1);
    host.set_req(1'b0);
    tick(DLY + 8);
    chk(sw, 1'b0);
  endtask
  task automatic t_cycle();
    start();
    setc(5'h04);
    tick(1);
    chk(sw, 1'b0);
    setc(5'h08);
    // Zero crossing only as a pulse: held into the on phase it reads as overcurrent
    setc('0);
    chk(sw, 1'b1);
    setc(5'h04);
    setc(5'h10);
    tick(1);
    chk(done, 1'b1);
    chk(st.full, 1'b1);
    setc(5'h08);
    tick(2);
    chk(sw, 1'b0);
    setc('0);
    host.set_req(1'b0);
    tick(2);
  endtask
  task automatic t_restart();
    start();
    host.set_req(1'b0);
    tick(1);
    chk(sw, 1'b0);
    start();
    host.set_req(1'b0);
    tick(2);
  endtask
  task automatic t_fault();
    comparators_t codes [3] = '{5'h08, 5'h02, 5'h01};
    comparators_t holds [3] = '{5'h04, 5'h04, 5'h01};
    for (int i = 0; i < 3; i++)
    begin
      start();
      setc(codes[i]);
      setc('0);
      tick(DLY + 6);
      chk(sw, 1'b0);
      chk(i == 2 ? st.thermal_latched : st.overcurrent_latched, 1'b1);
      // Peak current or thermal trip still present: a low request alone must not clear
      setc(holds[i]);
      host.set_req(1'b0);
      tick(2);
      chk(st.overcurrent_latched | st.thermal_latched, 1'b1);
      setc('0);
      tick(2);
      chk(st.overcurrent_latched | st.thermal_latched, 1'b0);
      start();
      host.set_req(1'b0);
      tick(2);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  initial
  begin
    srst = 1'b1;
    cmp = '0;
    repeat (8) @(posedge clk);
    #1 srst = 1'b0;
    t_flash();
    t_glitch();
    t_cycle();
    t_restart();
    t_fault();
    report_and_stop();
  end
endmodule
bind flash_charger_control flash_charger_control_asserts #(.DELAY_CYCLES(DELAY_CYCLES)) u_chk (
  .i_clk, .i_srst, .i_charge_request_pin, .i_cmp, .i_flash_permit, .i_flash_fire,
  .o_switch_on, .o_gate_drive_high, .o_gate_drive_low, .o_charge_done, .o_status);
`default_nettype wire
